// ---- rbw_pkg.sv ----
// reset, boot and wake sequencer: shared constants and types
// assumes a 32-bit avalon-mm slave with byte addresses and a single clock
package rbw_pkg;

    //------------------------------------------------------------
    // register map (byte offsets)
    //------------------------------------------------------------
    localparam logic [5:0] OFF_CTRL     = 6'h00;
    localparam logic [5:0] OFF_QUAL     = 6'h04;
    localparam logic [5:0] OFF_XCFG     = 6'h08;
    localparam logic [5:0] OFF_PLL      = 6'h0c;
    localparam logic [5:0] OFF_STAT     = 6'h10;
    localparam logic [5:0] OFF_IRQ_STAT = 6'h14;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h18;

    //------------------------------------------------------------
    // field positions and widths
    //------------------------------------------------------------
    localparam int CTRL_IDLE_BIT    = 0;
    localparam int CTRL_QUAL_BIT    = 1;
    localparam int CTRL_FSLEEP_BIT  = 2;
    localparam int XCFG_TIM_BIT     = 0;
    localparam int XCFG_EXT_IFACE_CLOCK_OUT_DIV_BIT = 1;
    localparam int QUAL_W           = 8;
    localparam int PLL_MULT_W       = 4;
    localparam int BOOT_W           = 4;
    localparam int STAT_MODE_LSB    = 0;
    localparam int STAT_IDLE_BIT    = 2;
    localparam int STAT_LOCK_BIT    = 3;
    localparam int STAT_BUSV_BIT    = 4;
    localparam int STAT_BOOTD_BIT   = 5;
    localparam int STAT_BOOTM_LSB   = 8;
    localparam int EV_BOOT          = 0;
    localparam int EV_LOCK          = 1;
    localparam int EV_WAKE          = 2;
    localparam int EV_HOLD          = 3;
    localparam int EV_W             = 4;
    localparam int TW               = 18;

    //------------------------------------------------------------
    // reset values
    //------------------------------------------------------------
    localparam logic [1:0]  XCFG_RST     = 2'h3;
    localparam logic [31:0] RDATA_UNMAP  = 32'h0000_0000;

    //------------------------------------------------------------
    // timing counts in clock cycles
    //------------------------------------------------------------
    localparam logic [TW-1:0] WD_RST_CYC    = 18'h00200;
    localparam logic [TW-1:0] BUS_DLY_CYC   = 18'h00020;
    localparam logic [TW-1:0] BOOT_SYS_CYC  = 18'h004ec;
    localparam logic [TW-1:0] BOOT_HOLD_CYC = 18'h009d8;
    localparam logic [TW-1:0] RESUME_FAST   = 18'h00008;
    localparam logic [TW-1:0] RESUME_SLEEP  = 18'h0041a;
    localparam int            IQT_MULT      = 5;
    localparam int            IQT_SCALE     = 2;

    typedef enum logic [1:0] {
        RBW_PLL_DIS = 2'b00,
        RBW_PLL_BYP = 2'b01,
        RBW_PLL_ENA = 2'b10
    } rbw_pll_mode_t;

    typedef enum logic [1:0] {
        RBW_WK_RUN    = 2'b00,
        RBW_WK_IDLE   = 2'b01,
        RBW_WK_RESUME = 2'b10
    } rbw_wake_st_t;

    // qualification window in system-clock cycles
    function automatic logic [TW-1:0] rbw_iqt(input logic [QUAL_W-1:0] qp);
        rbw_iqt = TW'(IQT_MULT * int'(qp) * IQT_SCALE);
    endfunction

endpackage

// ---- rbw_tmr_if.sv ----
// interval timer hookup between the sequencer and its timers
// assumes both ends share clk_sys
`timescale 1ns/10ps
interface rbw_tmr_if;
    logic          start;
    logic          tick;
    logic          clear;
    logic [17:0]   len;
    logic          busy;
    logic          done;

    modport ctl (output start, output tick, output clear, output len, input busy, input done);
    modport tmr (input start, input tick, input clear, input len, output busy, output done);
endinterface

// ---- rbw_timer.sv ----
// one-shot interval timer: busy for len ticks, then one-cycle done
// assumes start and tick come from logic on clk_sys
`timescale 1ns/10ps
module rbw_timer
    import rbw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    rbw_tmr_if.tmr   t
);
    logic [TW-1:0] cnt_r;

    always_ff @(posedge clk_sys) begin
        if (rst || t.clear) begin
            cnt_r  <= '0;
            t.busy <= 1'b0;
            t.done <= 1'b0;
        end else if (t.start) begin
            cnt_r  <= t.len;
            t.busy <= (t.len != '0);
            t.done <= 1'b0;
        end else if (t.busy && t.tick) begin
            t.done <= (cnt_r == TW'(1));
            t.busy <= (cnt_r != TW'(1));
            cnt_r  <= cnt_r - TW'(1);
        end else begin
            t.done <= 1'b0;
        end
    end
endmodule

// ---- rbw_seq_top.sv ----
// reset, boot-sampling, clock-output and idle-wake sequencer
// assumes clk_sys is the input clock, pins are asynchronous, avalon master on clk_sys
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
module rbw_seq_top
    import rbw_pkg::*;
#(
    parameter logic [17:0] PLL_LOCK_CYC = 18'h20000
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic        reset_pin_n_i,
    output logic             reset_pin_n_o,
    output logic             reset_pin_n_oe,
    input  wire logic        pll_disable_strap,
    input  wire logic [3:0]  boot_mode_pins,
    input  wire logic        nonmaskable_wake_input,
    input  wire logic        wake_irq,
    input  wire logic        watchdog_interrupt,
    input  wire logic        wd_reset_req,
    output logic             bus_valid,
    output logic             boot_done,
    output logic [3:0]       boot_mode_sel,
    output logic             clock_output_pin,
    output logic             idle_active,
    output logic             resume_pulse
);
    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    logic              rpin_s1_r, rpin_s2_r, strap_s1_r, strap_s2_r, nmi_s1_r, nmi_s2_r;
    logic [BOOT_W-1:0] boot_s1_r, boot_s2_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rpin_s1_r  <= 1'b0;
            rpin_s2_r  <= 1'b0;
            strap_s1_r <= 1'b1;
            strap_s2_r <= 1'b1;
            nmi_s1_r   <= 1'b0;
            nmi_s2_r   <= 1'b0;
            boot_s1_r  <= '0;
            boot_s2_r  <= '0;
        end else begin
            rpin_s1_r  <= reset_pin_n_i;
            rpin_s2_r  <= rpin_s1_r;
            strap_s1_r <= pll_disable_strap;
            strap_s2_r <= strap_s1_r;
            nmi_s1_r   <= nonmaskable_wake_input;
            nmi_s2_r   <= nmi_s1_r;
            boot_s1_r  <= boot_mode_pins;
            boot_s2_r  <= boot_s1_r;
        end
    end

    //------------------------------------------------------------
    // device reset and release
    //------------------------------------------------------------
    logic core_rst, core_q_r, rel;
    assign core_rst = rst | ~rpin_s2_r;
    assign rel      = core_q_r & ~core_rst;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            core_q_r <= 1'b1;
        end else begin
            core_q_r <= core_rst;
        end
    end

    //------------------------------------------------------------
    // timers
    //------------------------------------------------------------
    rbw_tmr_if tw_wd ();
    rbw_tmr_if tw_bus ();
    rbw_tmr_if tw_boot ();
    rbw_tmr_if tw_hold ();
    rbw_tmr_if tw_pll ();
    rbw_tmr_if tw_res ();

    rbw_timer u_wd   (.clk_sys(clk_sys), .rst(rst), .t(tw_wd.tmr));
    rbw_timer u_bus  (.clk_sys(clk_sys), .rst(rst), .t(tw_bus.tmr));
    rbw_timer u_boot (.clk_sys(clk_sys), .rst(rst), .t(tw_boot.tmr));
    rbw_timer u_hold (.clk_sys(clk_sys), .rst(rst), .t(tw_hold.tmr));
    rbw_timer u_pll  (.clk_sys(clk_sys), .rst(rst), .t(tw_pll.tmr));
    rbw_timer u_res  (.clk_sys(clk_sys), .rst(rst), .t(tw_res.tmr));

    //------------------------------------------------------------
    // register bus
    //------------------------------------------------------------
    logic                  wait_r, wr_acc, rd_take;
    logic                  qual_en_r, fsleep_r, irq_r;
    logic [QUAL_W-1:0]     qual_prd_r;
    logic [1:0]            xcfg_r;
    logic [PLL_MULT_W-1:0] pll_mult_r, pll_act_r;
    logic [EV_W-1:0]       irq_stat_r, irq_mask_r, ev;
    logic [31:0]           rdata_r, rdata_nxt, stat_w;
    logic                  idle_req, pll_start;
    rbw_pll_mode_t         mode_r;
    rbw_wake_st_t          state_r;
    logic                  boot_done_r, bus_valid_r;
    logic [BOOT_W-1:0]     boot_mode_r;

    assign wr_acc    = avs_write & ~wait_r;
    assign rd_take   = avs_read & wait_r;
    assign idle_req  = wr_acc && avs_address == OFF_CTRL && avs_writedata[CTRL_IDLE_BIT];
    assign pll_start = wr_acc && avs_address == OFF_PLL;

    // one wait cycle per access, then one ready cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_r  <= 1'b1;
            rdata_r <= '0;
        end else begin
            wait_r  <= ~((avs_read | avs_write) & wait_r);
            if (rd_take) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            qual_en_r  <= 1'b0;
            fsleep_r   <= 1'b0;
            qual_prd_r <= '0;
            xcfg_r     <= XCFG_RST;
            pll_mult_r <= '0;
            irq_mask_r <= '0;
        end else if (wr_acc) begin
            case (avs_address)
                OFF_CTRL: begin
                    qual_en_r <= avs_writedata[CTRL_QUAL_BIT];
                    fsleep_r  <= avs_writedata[CTRL_FSLEEP_BIT];
                end
                OFF_QUAL:     qual_prd_r <= avs_writedata[QUAL_W-1:0];
                OFF_XCFG:     xcfg_r     <= avs_writedata[1:0];
                OFF_PLL:      pll_mult_r <= avs_writedata[PLL_MULT_W-1:0];
                OFF_IRQ_MASK: irq_mask_r <= avs_writedata[EV_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // status clears by writing one; a new event in the same cycle wins
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            irq_stat_r <= '0;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~((wr_acc && avs_address == OFF_IRQ_STAT) ?
                          avs_writedata[EV_W-1:0] : '0)) | ev;
            irq_r      <= |(irq_stat_r & irq_mask_r);
        end
    end

    always_comb begin
        stat_w = '0;
        stat_w[STAT_MODE_LSB +: 2]      = mode_r;
        stat_w[STAT_IDLE_BIT]           = (state_r != RBW_WK_RUN);
        stat_w[STAT_LOCK_BIT]           = tw_pll.busy;
        stat_w[STAT_BUSV_BIT]           = bus_valid_r;
        stat_w[STAT_BOOTD_BIT]          = boot_done_r;
        stat_w[STAT_BOOTM_LSB +: BOOT_W] = boot_mode_r;
        case (avs_address)
            OFF_CTRL:     rdata_nxt = {29'h0, fsleep_r, qual_en_r, 1'b0};
            OFF_QUAL:     rdata_nxt = {24'h0, qual_prd_r};
            OFF_XCFG:     rdata_nxt = {30'h0, xcfg_r};
            OFF_PLL:      rdata_nxt = {28'h0, pll_act_r};
            OFF_STAT:     rdata_nxt = stat_w;
            OFF_IRQ_STAT: rdata_nxt = {28'h0, irq_stat_r};
            OFF_IRQ_MASK: rdata_nxt = {28'h0, irq_mask_r};
            default:      rdata_nxt = RDATA_UNMAP;
        endcase
    end

    //------------------------------------------------------------
    // watchdog reset pulse and external bus delay
    //------------------------------------------------------------
    assign tw_wd.start  = wd_reset_req & ~tw_wd.busy;
    assign tw_wd.tick   = 1'b1;
    assign tw_wd.clear  = 1'b0;
    assign tw_wd.len    = WD_RST_CYC;

    assign tw_bus.start = rel;
    assign tw_bus.tick  = 1'b1;
    assign tw_bus.clear = core_rst;
    assign tw_bus.len   = BUS_DLY_CYC;

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            bus_valid_r <= 1'b0;
        end else if (tw_bus.done) begin
            bus_valid_r <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // clock mode and system-clock tick
    //------------------------------------------------------------
    logic strap_r, phase_r, sys_tick;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strap_r <= 1'b1;
        end else if (rel) begin
            strap_r <= strap_s2_r;
        end
    end

    assign tw_pll.start = pll_start & ~core_rst;
    assign tw_pll.tick  = 1'b1;
    assign tw_pll.clear = core_rst;
    assign tw_pll.len   = PLL_LOCK_CYC;

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            pll_act_r <= '0;
            mode_r    <= RBW_PLL_BYP;
            phase_r   <= 1'b0;
        end else begin
            if (tw_pll.done) begin
                pll_act_r <= pll_mult_r;
            end
            mode_r  <= !strap_r ? RBW_PLL_DIS : (pll_act_r == '0 ? RBW_PLL_BYP : RBW_PLL_ENA);
            phase_r <= ~phase_r;
        end
    end

    // bypass halves the input; disabled and enabled step every cycle
    assign sys_tick = (mode_r == RBW_PLL_BYP) ? phase_r : 1'b1;

    //------------------------------------------------------------
    // clock output divider
    //------------------------------------------------------------
    logic [1:0] hp_cnt_r, hp_len;
    logic       clk_out_r;

    assign hp_len = (xcfg_r == 2'h3) ? 2'h2 : 2'h1;

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            hp_cnt_r  <= '0;
            clk_out_r <= 1'b0;
        end else if (sys_tick) begin
            if (hp_cnt_r + 2'h1 >= hp_len) begin
                hp_cnt_r  <= '0;
                clk_out_r <= ~clk_out_r;
            end else begin
                hp_cnt_r  <= hp_cnt_r + 2'h1;
            end
        end
    end

    //------------------------------------------------------------
    // boot sampling
    //------------------------------------------------------------
    logic [BOOT_W-1:0] boot_ref_r;

    assign tw_boot.start = rel;
    assign tw_boot.tick  = sys_tick;
    assign tw_boot.clear = core_rst;
    assign tw_boot.len   = BOOT_SYS_CYC;
    assign tw_hold.start = rel;
    assign tw_hold.tick  = 1'b1;
    assign tw_hold.clear = core_rst;
    assign tw_hold.len   = BOOT_HOLD_CYC;

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            boot_done_r <= 1'b0;
            boot_mode_r <= '0;
            boot_ref_r  <= '0;
        end else begin
            if (rel) begin
                boot_ref_r <= boot_s2_r;
            end
            if (tw_boot.done) begin
                boot_done_r <= 1'b1;
                boot_mode_r <= boot_s2_r;
            end
        end
    end

    //------------------------------------------------------------
    // idle and wake
    //------------------------------------------------------------
    logic          raw_wake, qual_ok, resume_r, idle_r;
    logic [TW-1:0] qcnt_r;
    rbw_wake_st_t  state_nxt;

    assign raw_wake = wake_irq | watchdog_interrupt | nmi_s2_r;
    assign qual_ok  = raw_wake & (~qual_en_r |
                      (sys_tick && qcnt_r + TW'(1) >= rbw_iqt(qual_prd_r)));
    assign tw_res.start = (state_r == RBW_WK_IDLE) & qual_ok;
    assign tw_res.tick  = sys_tick;
    assign tw_res.clear = core_rst;
    assign tw_res.len   = fsleep_r ? RESUME_SLEEP : RESUME_FAST;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RBW_WK_RUN:    if (idle_req) state_nxt = RBW_WK_IDLE;
            RBW_WK_IDLE:   if (qual_ok) state_nxt = RBW_WK_RESUME;
            RBW_WK_RESUME: if (tw_res.done) state_nxt = RBW_WK_RUN;
            default:       state_nxt = RBW_WK_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            state_r  <= RBW_WK_RUN;
            qcnt_r   <= '0;
            resume_r <= 1'b0;
            idle_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            idle_r   <= (state_nxt != RBW_WK_RUN);
            resume_r <= tw_res.done;
            if (state_r != RBW_WK_IDLE || !raw_wake) begin
                qcnt_r <= '0;
            end else if (sys_tick) begin
                qcnt_r <= qcnt_r + TW'(1);
            end
        end
    end

    always_comb begin
        ev          = '0;
        ev[EV_BOOT] = tw_boot.done;
        ev[EV_LOCK] = tw_pll.done;
        ev[EV_WAKE] = tw_res.done;
        ev[EV_HOLD] = tw_hold.busy && boot_s2_r != boot_ref_r;
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    assign avs_readdata     = rdata_r;
    assign avs_waitrequest  = wait_r;
    assign irq              = irq_r;
    assign reset_pin_n_o    = 1'b0;
    assign reset_pin_n_oe   = tw_wd.busy;
    assign bus_valid        = bus_valid_r;
    assign boot_done        = boot_done_r;
    assign boot_mode_sel    = boot_mode_r;
    assign clock_output_pin = clk_out_r;
    assign idle_active      = idle_r;
    assign resume_pulse     = resume_r;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic [TW-1:0] oe_len_r, pll_len_r, res_len_r;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            oe_len_r  <= '0;
            pll_len_r <= '0;
            res_len_r <= '0;
        end else begin
            oe_len_r  <= tw_wd.busy ? oe_len_r + TW'(1) : '0;
            pll_len_r <= tw_pll.start ? '0 : pll_len_r + TW'(1);
            res_len_r <= tw_res.start ? '0 : res_len_r + TW'(sys_tick);
        end
    end

    sequence bus_quiet_s;
        !bus_valid_r [*1] ##31 !bus_valid_r;
    endsequence
    sequence bus_rise_s;
        ##1 bus_valid_r;
    endsequence

    wd_pulse_len_a: assert property ($fell(reset_pin_n_oe) |-> oe_len_r == WD_RST_CYC)
        else $error("watchdog reset pulse length wrong");
    bus_valid_dly_a: assert property (disable iff (core_rst) rel |-> ##1 bus_quiet_s ##1 bus_rise_s)
        else $error("bus valid delay wrong");
    boot_sample_a: assert property (tw_boot.done |=> boot_done_r && boot_mode_r == $past(boot_s2_r))
        else $error("boot pins not sampled at boot timer end");
    pll_lock_wait_a: assert property ($changed(pll_act_r) && !$past(core_rst) |->
        $past(pll_len_r) == PLL_LOCK_CYC)
        else $error("pll multiplier applied before lock count");
    qual_time_a: assert property (tw_res.start && qual_en_r |-> qcnt_r + TW'(1) >= rbw_iqt(qual_prd_r))
        else $error("wake accepted before qualification time");
    resume_lat_a: assert property ($rose(resume_pulse) |->
        $past(res_len_r) == (fsleep_r ? RESUME_SLEEP : RESUME_FAST))
        else $error("resume latency wrong");
    idle_exit_a: assert property ($fell(idle_r) |-> $past(tw_res.done) || $past(core_rst))
        else $error("idle left without resume or reset");
    counter_clear_a: assert property (core_rst |=> !tw_boot.busy && !tw_bus.busy && !tw_res.busy)
        else $error("interval counters not cleared by reset");
    pll_mode_a: assert property (rel && !strap_s2_r |=> ##1 mode_r == RBW_PLL_DIS)
        else $error("strap low did not disable pll");
    xcfg_reset_a: assert property ($past(core_rst) && !core_rst |-> xcfg_r == XCFG_RST)
        else $error("clock output divider bits not reset to one");
endmodule

// ---- rbw_ext_model.sv ----
// far side of the sequencer: reset source, pull-up on the reset pin, strap pins
// assumes the dut pulls the reset pin low only through its output enable
`timescale 1ns/10ps
module rbw_ext_model (
    input  wire logic       reset_pin_n_oe,
    input  wire logic       ext_rst_n,
    input  wire logic       strap_low,
    output logic            reset_pin_n_i,
    output logic            pll_disable_strap,
    output logic      [3:0] boot_mode_pins
);
    // pull-up wins unless either party pulls low; source holds low 8+ stable clocks
    assign reset_pin_n_i     = ~reset_pin_n_oe & ext_rst_n;
    assign pll_disable_strap = ~strap_low;
    // boot mode straps held for the whole run, far beyond the hold window
    assign boot_mode_pins    = 4'ha;
endmodule

// ---- testbench.sv ----
// self-checking bench for the reset, boot and wake sequencer
// assumes rbw_pkg, rbw_seq_top and rbw_ext_model are compiled first
`timescale 1ns/10ps
module testbench;
    import rbw_pkg::*;
    logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest, irq, ext_rst_n;
    logic        reset_pin_n_i, reset_pin_n_oe, pll_disable_strap, nonmaskable_wake_input;
    logic        wake_irq, watchdog_interrupt, wd_reset_req, bus_valid, boot_done;
    logic        clock_output_pin, idle_active, resume_pulse, strap_low;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  boot_mode_pins, boot_mode_sel;
    int          mismatches, tests_run, cyc, t0;

    rbw_seq_top #(.PLL_LOCK_CYC(18'h00040)) dut (.clk_sys(clk_sys), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .reset_pin_n_i(reset_pin_n_i),
        .reset_pin_n_o(), .reset_pin_n_oe(reset_pin_n_oe), .pll_disable_strap(pll_disable_strap),
        .boot_mode_pins(boot_mode_pins), .nonmaskable_wake_input(nonmaskable_wake_input),
        .wake_irq(wake_irq), .watchdog_interrupt(watchdog_interrupt), .wd_reset_req(wd_reset_req),
        .bus_valid(bus_valid), .boot_done(boot_done), .boot_mode_sel(boot_mode_sel),
        .clock_output_pin(clock_output_pin), .idle_active(idle_active), .resume_pulse(resume_pulse));
    rbw_ext_model ext (.reset_pin_n_oe(reset_pin_n_oe), .ext_rst_n(ext_rst_n), .strap_low(strap_low),
        .reset_pin_n_i(reset_pin_n_i), .pll_disable_strap(pll_disable_strap),
        .boot_mode_pins(boot_mode_pins));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;

    //------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------
    task automatic stop_test;
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task automatic t_boot(input int bl);
        t0 = cyc;
        while (bus_valid !== 1'b1) @(posedge clk_sys);
        chk(cyc - t0 >= 33 && cyc - t0 <= 38, "bus valid delay");
        while (boot_done !== 1'b1) @(posedge clk_sys);
        chk(cyc - t0 >= bl && cyc - t0 <= bl + 15, "boot sample delay");
        chk(boot_mode_sel === 4'ha, "boot mode");
    endtask
    task automatic t_regs;
        bus(1'b0, OFF_XCFG, 32'h0);
        chk(q === 32'h0000_0003, "clock cfg reset");
        bus(1'b0, 6'h3c, 32'h0);
        chk(q === RDATA_UNMAP, "unmapped read");
        bus(1'b0, OFF_STAT, 32'h0);
        chk(q[1:0] === RBW_PLL_BYP, "bypass mode");
        while (clock_output_pin !== 1'b0) @(posedge clk_sys);
        while (clock_output_pin !== 1'b1) @(posedge clk_sys);
        t0 = cyc;
        while (clock_output_pin !== 1'b0) @(posedge clk_sys);
        while (clock_output_pin !== 1'b1) @(posedge clk_sys);
        chk(cyc - t0 == 8, "clock output period");
    endtask
    task automatic t_pll;
        bus(1'b1, OFF_IRQ_MASK, 32'h2);
        bus(1'b1, OFF_PLL, 32'h2);
        t0 = cyc;
        while (irq !== 1'b1) @(posedge clk_sys);
        chk(cyc - t0 >= 64 && cyc - t0 <= 70, "pll lock wait");
        bus(1'b0, OFF_PLL, 32'h0);
        chk(q === 32'h0000_0002, "pll multiplier");
        bus(1'b0, OFF_STAT, 32'h0);
        chk(q[1:0] === RBW_PLL_ENA, "enabled mode");
        bus(1'b1, OFF_IRQ_STAT, 32'h2);
        @(posedge clk_sys);
        chk(irq === 1'b0, "irq clear");
    endtask
    task automatic t_wake(input logic [2:0] ctl, input logic [2:0] src, input int hold, input int lo,
                          input int hi);
        bus(1'b1, OFF_CTRL, {29'h0, ctl});
        @(posedge clk_sys);
        chk(idle_active === 1'b1, "idle entry");
        {nonmaskable_wake_input, watchdog_interrupt, wake_irq} <= src;
        t0 = cyc;
        repeat (hold) @(posedge clk_sys);
        {nonmaskable_wake_input, watchdog_interrupt, wake_irq} <= 3'h0;
        while (resume_pulse !== 1'b1 && cyc - t0 < 3000) @(posedge clk_sys);
        chk(cyc - t0 >= lo && cyc - t0 <= hi, "resume latency");
        @(posedge clk_sys);
        chk(idle_active === 1'b0, "idle exit");
    endtask
    task automatic t_wdog;
        strap_low <= 1'b1;
        wd_reset_req <= 1'b1;
        @(posedge clk_sys);
        wd_reset_req <= 1'b0;
        while (reset_pin_n_oe !== 1'b1) @(posedge clk_sys);
        t0 = cyc;
        while (reset_pin_n_oe !== 1'b0) @(posedge clk_sys);
        chk(cyc - t0 == 512, "watchdog pulse");
        chk(bus_valid === 1'b0, "core held in reset");
        t_boot(1260);
        bus(1'b0, OFF_STAT, 32'h0);
        chk(q[1:0] === RBW_PLL_DIS, "disabled mode");
    endtask

    initial begin
        {mismatches, tests_run, cyc} = '0;
        {rst, ext_rst_n, avs_read, avs_write, wd_reset_req} = 5'b10000;
        {nonmaskable_wake_input, watchdog_interrupt, wake_irq} = 3'h0;
        strap_low = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        ext_rst_n <= 1'b1;
        t_boot(2520);
        t_regs();
        t_pll();
        t_wake(3'h1, 3'h1, 2, 8, 13);
        t_wake(3'h5, 3'h2, 2, 1050, 1056);
        bus(1'b1, OFF_QUAL, 32'h3);
        t_wake(3'h3, 3'h4, 34, 38, 46);
        t_wdog();
        stop_test();
    end
    initial begin
        #(25 * 20000);
        mismatches++;
        stop_test();
    end
endmodule
